// ---- sgr_pkg.sv ----
package sgr_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] OFS_GEO  = 4'h0;  // sdram_geometry_config
  localparam logic [3:0] OFS_RFC  = 4'h4;  // refresh_control
  localparam logic [3:0] OFS_TIM1 = 4'h8;  // first_timing_register

  // field positions
  localparam int CL_LSB     = 9;   // cas_latency_field 11:9
  localparam int BANK_LSB   = 4;   // bank_count_field 6:4
  localparam int PAGE_LSB   = 0;   // page_words_field 2:0
  localparam int UNLOCK_BIT = 15;  // timing_write_unlock
  localparam int SR_BIT     = 31;  // self_refresh_request
  localparam int TRFC_LSB   = 25;  // refresh cycle time 31:25
  localparam int RATE_W     = 16;  // refresh interval width

  // values after reset
  localparam logic [2:0]  CL_RST     = 3'h5;
  localparam logic [2:0]  BANK_RST   = 3'h2;
  localparam logic [2:0]  PAGE_RST   = 3'h0;
  localparam logic        UNLOCK_RST = 1'h0;
  localparam logic [6:0]  TRFC_RST   = 7'h3f;
  localparam logic [15:0] RATE_RST   = 16'h0753;

  // smallest interval accepted as written
  localparam logic [15:0] RATE_MIN   = 16'h0100;
  // column bits and page words for page code 0
  localparam logic [3:0]  COL_BASE   = 4'h8;
  localparam logic [11:0] WORDS_BASE = 12'h100;

  // controller refresh states
  typedef enum logic {
    SGR_RUN,   // periodic auto-refresh
    SGR_SELF   // memory held in self-refresh
  } sgr_state_e;

  // geometry fields as held
  typedef struct packed {
    logic       unlock;  // timing_write_unlock
    logic [2:0] cl;      // cas_latency_field
    logic [2:0] bank;    // bank_count_field
    logic [2:0] page;    // page_words_field
  } sgr_geo_s;

  // whole state of the top block apart from the interval counter
  typedef struct packed {
    sgr_geo_s    geo;    // geometry register
    logic [6:0]  trfc;   // refresh cycle time
    logic        sr;     // self-refresh request
    logic [15:0] rate;   // refresh interval
    sgr_state_e  st;     // refresh state
    logic        ack;    // bus acknowledge
    logic [31:0] dat;    // bus read data
    logic        init;   // init launch pulse
    logic        reload; // interval reload pulse
    logic [2:0]  lat;    // decoded read latency
    logic [3:0]  banks;  // decoded bank count
    logic [3:0]  colb;   // decoded column bits
    logic [11:0] words;  // decoded page words
  } sgr_top_s;

  localparam sgr_top_s TOP_RST = '{
    geo: '{unlock: UNLOCK_RST, cl: CL_RST, bank: BANK_RST, page: PAGE_RST},
    trfc: TRFC_RST, sr: 1'h0, rate: RATE_RST, st: SGR_RUN,
    ack: 1'h0, dat: 32'h0000_0000, init: 1'h0, reload: 1'h0,
    lat: CL_RST, banks: 4'h4, colb: 4'h8, words: 12'h100};

endpackage

// ---- sgr_interval_counter.sv ----
`timescale 1ns/1ps

// down-counter giving one tick per programmed period
module sgr_interval_counter #(
  parameter int W = 16                    // period width
) (
  input  wire logic         clk_i,        // clock
  input  wire logic         rst_i,        // sync reset, high
  input  wire logic         reload_i,     // restart from period
  input  wire logic         hold_i,       // freeze the count
  input  wire logic [W-1:0] period_i,     // clocks per tick
  output logic              tick_o        // one-cycle tick
);

  // a one-bit counter cannot hold a period
  if (W < 2) begin : g_chk
    $error("sgr_interval_counter: W must be at least 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;   // clocks left
    logic         tick;  // tick flop
  } sgr_cnt_s;

  sgr_cnt_s s_r;    // state
  sgr_cnt_s s_nxt;  // next state

  // next-state logic
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (reload_i) begin
      // new rate counts from a full period
      s_nxt.cnt = period_i;
    end else if (hold_i) begin
      // frozen during self-refresh
      s_nxt.cnt = s_r.cnt;
    end else if (s_r.cnt <= W'(1)) begin
      // period spent: tick and restart; zero acts as one
      s_nxt.tick = 1'b1;
      s_nxt.cnt  = period_i;
    end else begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // starts on the interval value after reset
      s_r <= '{cnt: W'(sgr_pkg::RATE_RST), tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule // sgr_interval_counter

// ---- sgr_config_refresh.sv ----
// Operation
// - cas latency field sets read latency
// - latency write launches memory initialization
// - latency writable only while timing unlocked
// - bank code gives 1,2,4,8 banks
// - page code gives words and column bits
// - bank or page write launches initialization
// - unused geometry bits read zero, ignored
// - self-refresh bit enters and leaves self-refresh
// - one auto-refresh per programmed interval clocks
// - interval below 0x100 loads twice refresh time
// - unlock bit gates timing register writes
// - timing register holds refresh cycle time
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

module sgr_config_refresh #(
  parameter int ADR_W = 4                      // byte address width
) (
  input  wire logic        clk_i,              // clock, 25 MHz
  input  wire logic        rst_i,              // sync reset, high
  // classic wishbone slave
  input  wire logic [ADR_W-1:0] adr_i,         // byte address
  input  wire logic [31:0] dat_i,              // write data
  input  wire logic [3:0]  sel_i,              // byte lanes
  input  wire logic        we_i,               // write enable
  input  wire logic        cyc_i,              // bus cycle
  input  wire logic        stb_i,              // strobe
  output logic      [31:0] dat_o,              // read data
  output logic             ack_o,              // acknowledge
  // toward the memory command side
  output logic             init_start_o,       // start init pulse
  output logic      [2:0]  cas_latency_o,      // read latency
  output logic      [3:0]  bank_count_o,       // internal banks
  output logic      [3:0]  column_bits_o,      // column addr bits
  output logic      [11:0] page_words_o,       // words per page
  output logic      [6:0]  refresh_cycle_o,    // refresh cycle time
  output logic             self_refresh_o,     // in self-refresh
  output logic             refresh_req_o       // auto-refresh pulse
);

  // the offsets need four address bits
  if (ADR_W < 4) begin : g_chk
    $error("sgr_config_refresh: ADR_W must be at least 4");
  end

  sgr_pkg::sgr_top_s s_r;    // state
  sgr_pkg::sgr_top_s s_nxt;  // next state

  logic        req;          // new bus request
  logic        wr;           // new write request
  logic [31:0] wmask;        // byte-lane mask
  logic [31:0] rd;           // read mux
  logic [15:0] rate_new;     // merged interval
  logic [15:0] rate_alt;     // twice refresh time
  logic        tick;         // interval elapsed

  // next-state logic
  always_comb begin
    s_nxt        = s_r;
    s_nxt.ack    = 1'b0;
    s_nxt.init   = 1'b0;
    s_nxt.reload = 1'b0;

    // ack is dropped in the cycle after it was given
    req   = cyc_i & stb_i & ~s_r.ack;
    wr    = req & we_i;
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
             {8{sel_i[1]}}, {8{sel_i[0]}}};

    // fallback interval from the timing register
    rate_alt = {8'h00, s_r.trfc, 1'b0};
    // untouched lanes keep the old interval
    rate_new = (dat_i[15:0] & wmask[15:0])
             | (s_r.rate & ~wmask[15:0]);

    // read mux; unused bits read as zero
    rd = 32'h0000_0000;
    case (adr_i[3:0])
      sgr_pkg::OFS_GEO: begin
        rd[sgr_pkg::UNLOCK_BIT] = s_r.geo.unlock;
        rd[sgr_pkg::CL_LSB +: 3]   = s_r.geo.cl;
        rd[sgr_pkg::BANK_LSB +: 3] = s_r.geo.bank;
        rd[sgr_pkg::PAGE_LSB +: 3] = s_r.geo.page;
      end
      sgr_pkg::OFS_RFC: begin
        // bits 30:16 are not stored
        rd[sgr_pkg::SR_BIT]     = s_r.sr;
        rd[0 +: sgr_pkg::RATE_W] = s_r.rate;
      end
      sgr_pkg::OFS_TIM1: begin
        rd[sgr_pkg::TRFC_LSB +: 7] = s_r.trfc;
      end
      default: begin
        // unmapped: acked, reads zero
        rd = 32'h0000_0000;
      end
    endcase

    // single-wait acknowledge; data sampled with ack
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = rd;
    end

    // register writes take effect with the ack edge
    if (wr) begin
      case (adr_i[3:0])
        sgr_pkg::OFS_GEO: begin
          if (sel_i[1]) begin
            // old lock state gates this write
            if (s_r.geo.unlock) begin
              s_nxt.geo.cl = dat_i[sgr_pkg::CL_LSB +: 3];
              s_nxt.init   = 1'b1;
            end
            s_nxt.geo.unlock = dat_i[sgr_pkg::UNLOCK_BIT];
          end
          if (sel_i[0]) begin
            // bits 7 and 3 are dropped here
            s_nxt.geo.bank = dat_i[sgr_pkg::BANK_LSB +: 3];
            s_nxt.geo.page = dat_i[sgr_pkg::PAGE_LSB +: 3];
            s_nxt.init     = 1'b1;
          end
        end
        sgr_pkg::OFS_RFC: begin
          if (sel_i[3]) begin
            s_nxt.sr = dat_i[sgr_pkg::SR_BIT];
          end
          if (sel_i[1] | sel_i[0]) begin
            // too short an interval would starve traffic
            if (rate_new < sgr_pkg::RATE_MIN) begin
              s_nxt.rate = rate_alt;
            end else begin
              s_nxt.rate = rate_new;
            end
            s_nxt.reload = 1'b1;
          end
        end
        sgr_pkg::OFS_TIM1: begin
          if (sel_i[3] & s_r.geo.unlock) begin
            s_nxt.trfc = dat_i[sgr_pkg::TRFC_LSB +: 7];
          end
        end
        default: begin
          // write to a hole is ignored
          s_nxt.init = 1'b0;
        end
      endcase
    end

    // refresh state follows the request bit
    case (s_r.st)
      sgr_pkg::SGR_RUN: begin
        if (s_nxt.sr) begin
          s_nxt.st = sgr_pkg::SGR_SELF;
        end
      end
      sgr_pkg::SGR_SELF: begin
        if (!s_nxt.sr) begin
          // count restarts from a full interval
          s_nxt.st     = sgr_pkg::SGR_RUN;
          s_nxt.reload = 1'b1;
        end
      end
      default: begin
        s_nxt.st = sgr_pkg::SGR_RUN;
      end
    endcase

    // decoded geometry; reserved codes use low bits
    s_nxt.lat   = s_nxt.geo.cl;
    s_nxt.banks = 4'h1 << s_nxt.geo.bank[1:0];
    s_nxt.colb  = sgr_pkg::COL_BASE
                + {2'b00, s_nxt.geo.page[1:0]};
    s_nxt.words = sgr_pkg::WORDS_BASE
                << s_nxt.geo.page[1:0];
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= sgr_pkg::TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // refresh interval timer, frozen in self-refresh
  sgr_interval_counter #(
    .W        (sgr_pkg::RATE_W)
  ) u_interval (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .reload_i (s_r.reload),
    .hold_i   (s_r.st == sgr_pkg::SGR_SELF),
    .period_i (s_r.rate),
    .tick_o   (tick)
  );

  // outputs straight from flops
  assign dat_o           = s_r.dat;
  assign ack_o           = s_r.ack;
  assign init_start_o    = s_r.init;
  assign cas_latency_o   = s_r.lat;
  assign bank_count_o    = s_r.banks;
  assign column_bits_o   = s_r.colb;
  assign page_words_o    = s_r.words;
  assign refresh_cycle_o = s_r.trfc;
  assign self_refresh_o  = (s_r.st == sgr_pkg::SGR_SELF);
  assign refresh_req_o   = tick;

endmodule // sgr_config_refresh

// ---- sgr_config_refresh_sva.sv ----
`timescale 1ns/1ps
// watches the bus handshake and the memory-side outputs of the block except latency and refresh cycle
module sgr_config_refresh_sva #(
  parameter int ADR_W = 4                // byte address width
) (
  input wire logic             clk_i,           // clock
  input wire logic             rst_i,           // sync reset
  input wire logic [ADR_W-1:0] adr_i,           // byte address
  input wire logic [31:0]      dat_i,           // write data
  input wire logic [3:0]       sel_i,           // byte lanes
  input wire logic             we_i,            // write enable
  input wire logic             cyc_i,           // bus cycle
  input wire logic             stb_i,           // strobe
  input wire logic [31:0]      dat_o,           // read data
  input wire logic             ack_o,           // acknowledge
  input wire logic             init_start_o,    // init launch
  input wire logic [3:0]       bank_count_o,    // banks
  input wire logic [3:0]       column_bits_o,   // column bits
  input wire logic [11:0]      page_words_o,    // page words
  input wire logic             self_refresh_o,  // asleep
  input wire logic             refresh_req_o    // refresh pulse
);
  wire tk = cyc_i && stb_i && !ack_o;  // request taken at this edge
  wire wg = tk && we_i && adr_i == 4'h0;  // geometry write
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (tk |=> ack_o) else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_init_cause: assert property (init_start_o |-> $past(wg)) else $error("stray init");
  a_init_lane0: assert property (wg && sel_i[0] |=> init_start_o) else $error("no init");
  a_bank_pow: assert property ($onehot(bank_count_o)) else $error("bad banks");
  a_page_words: assert property (page_words_o == 12'h100 << (column_bits_o - 4'h8))
    else $error("bad page");
  a_rsvd_zero: assert property (ack_o && $past(tk && !we_i && adr_i == 4'h0)
    |-> dat_o[8:7] == 2'h0 && !dat_o[3]) else $error("reserved bits set");
  a_sr_follow: assert property (tk && we_i && adr_i == 4'h4 && sel_i[3]
    |=> ##1 self_refresh_o == $past(dat_i[31], 2)) else $error("self-refresh wrong");
  a_sr_quiet: assert property (self_refresh_o && $past(self_refresh_o)
    |-> !refresh_req_o) else $error("refresh while asleep");
endmodule  // sgr_config_refresh_sva

bind sgr_config_refresh sgr_config_refresh_sva #(.ADR_W(ADR_W)) sva_u (.clk_i, .rst_i, .adr_i, .dat_i,
  .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .init_start_o, .bank_count_o, .column_bits_o,
  .page_words_o, .self_refresh_o, .refresh_req_o);

// ---- sgr_mem_model.sv ----
`timescale 1ns/1ps
// memory-side stand-in: counts launches and stray refreshes
module sgr_mem_model (
  input  wire logic       clk_i,           // clock
  input  wire logic       rst_i,           // sync reset
  input  wire logic       init_start_i,    // init launch
  input  wire logic       refresh_req_i,   // auto-refresh
  input  wire logic       self_refresh_i,  // asleep
  output logic      [7:0] init_cnt_o,      // launches seen
  output logic      [7:0] sr_bad_o         // refreshes while asleep
);
  logic sr_q;  // asleep one cycle ago
  // a refresh sent to a sleeping device would upset its own timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_o <= 8'h00;
      sr_bad_o   <= 8'h00;
      sr_q       <= 1'b0;
    end else begin
      sr_q <= self_refresh_i;
      if (init_start_i) init_cnt_o <= init_cnt_o + 8'h01;
      if (sr_q && self_refresh_i && refresh_req_i) sr_bad_o <= sr_bad_o + 8'h01;
    end
  end
endmodule  // sgr_mem_model

// ---- test_sgr_config_refresh.sv ----
`timescale 1ns/1ps
// drives the register bus and checks geometry and refresh behaviour
module test_sgr_config_refresh;
  logic        clk_i = 1'b0;  // 25 MHz
  logic        rst_i = 1'b1;  // sync reset
  logic [3:0]  adr_i = 4'h0;  // byte address
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, init_start_o, self_refresh_o, refresh_req_o;
  logic [2:0]  cas_latency_o;
  logic [3:0]  bank_count_o, column_bits_o;
  logic [11:0] page_words_o;
  logic [6:0]  refresh_cycle_o;
  logic [7:0]  init_cnt, sr_bad;  // memory model counts
  logic [31:0] exp_q[$];  // expected read data, oldest first
  int          err_count = 0;
  int          n_checks = 0;

  always #20 clk_i = ~clk_i;  // 40 ns period

  sgr_config_refresh dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .init_start_o, .cas_latency_o, .bank_count_o, .column_bits_o, .page_words_o, .refresh_cycle_o,
    .self_refresh_o, .refresh_req_o);
  sgr_mem_model mem_u (.clk_i, .rst_i, .init_start_i(init_start_o), .refresh_req_i(refresh_req_o),
    .self_refresh_i(self_refresh_o), .init_cnt_o(init_cnt), .sr_bad_o(sr_bad));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(a, 1'b1, d, s);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0, 4'hf);
  endtask

  // edges until the next refresh pulse
  task automatic wp(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (refresh_req_o !== 1'b1 && n < 70000);
  endtask

  // skip two pulses so a reload in flight cannot skew the figure
  task automatic gap(input int e);
    int n;
    wp(n);
    wp(n);
    wp(n);
    chk(n, e);
  endtask

  // read data is compared where the ack is sampled
  always @(posedge clk_i) if (ack_o === 1'b1 && !we_i && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    int          n;
    void'($urandom(89));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_0a20);
    rd(4'h8, 32'h7e00_0000);
    wr(4'h0, 32'h0000_0600, 4'h2);  // latency 3 while locked
    chk(cas_latency_o, 32'h5);
    wr(4'h0, 32'h0000_8a00, 4'h2);  // unlock only
    @(posedge clk_i);  // a stray launch needs one edge to reach the model
    chk(init_cnt, 32'h0);
    // every legal latency, bank and page code, junk in reserved bits
    for (int i = 0; i < 4; i++) begin
      r = 32'h8000 | (i + 2) << 9 | i << 4 | i;
      wr(4'h0, r | $urandom & 32'h188, 4'h3);
      rd(4'h0, r);
      chk(init_cnt, i + 1);
      chk(cas_latency_o, i + 2);
      chk(bank_count_o, 1 << i);
      chk({column_bits_o, page_words_o}, (8 + i) << 12 | 256 << i);
    end
    wr(4'h8, 32'h5000_0000, 4'h8);
    wr(4'h4, 32'h0000_0100, 4'h3);
    wp(n);
    chk(n, 257);
    gap(256);
    wr(4'h4, 32'h0000_00ff, 4'h3);
    rd(4'h4, 32'h0000_0050);
    gap(80);
    wr(4'h4, 32'h8000_0000, 4'h8);
    repeat (300) @(posedge clk_i);
    chk(self_refresh_o, 32'h1);
    rd(4'h4, 32'h8000_0050);
    wr(4'h4, 32'h0, 4'h8);
    chk(self_refresh_o, 32'h0);
    wp(n);
    chk(n, 81);
    gap(80);
    chk(sr_bad, 32'h0);
    wr(4'h0, 32'h0000_0a00, 4'h2);  // lock again
    wr(4'h8, 32'hfe00_0000, 4'h8);
    rd(4'h8, 32'h5000_0000);
    chk(refresh_cycle_o, 32'h28);
    wr(4'hc, $urandom, 4'hf);  // unmapped place
    rd(4'hc, 32'h0);
    repeat (4) @(posedge clk_i);
    finish_test();
  end

  // about 2000 cycles are needed; far beyond that means a hang
  initial begin
    #2_000_000;
    err_count++;
    finish_test();
  end
endmodule  // test_sgr_config_refresh
